/* File: hw/tarc_defs.svh */
// How it works
// (RULE1) Any reset restores setup configuration defaults
// (RULE2) Software reset byte restores full default configuration
// (RULE3) Software reset needs healthy interface; resync does not
// (RULE4) Keyed 24-bit pattern resets like power-up; resync restores defaults but sequencer stays ready, no POR phase
// (RULE5) Pattern recognised only while chip selected
// (RULE6) Host uses pattern when deselect fails
// (RULE7) Power-on reset gives default working condition
// (RULE8) Host init sends pattern if POR doubtful
// (RULE9) Host waits 200 ns after software reset
// (RULE10) Host waits 2 ms after power-up; testbench waits only for ready_out, at most 100 clocks
`ifndef TARC_DEFS_SVH
`define TARC_DEFS_SVH
// ==========================================
// Codes and defaults
`define TARC_SW_RESET_CODE 8'hA1
`define TARC_RESYNC_KEY    24'h06D926
`define TARC_SETUP_DEFAULT 3'h0
`define TARC_CTRL_DEFAULT  8'h00
`define TARC_SETUP_OPCODE  3'h2
`define TARC_SETUP_LSB     1
`define TARC_SETUP_MSB     3
`define TARC_OP_LSB        4
`define TARC_OP_MSB        6
`define TARC_CTRL_START    7
`define TARC_POR_CYCLES    4'hF
`endif

/* File: hw/tarc_pkg.sv */
package tarc_pkg;
  typedef enum logic [1:0] {
    TARC_POR   = 2'b00,
    TARC_READY = 2'b01,
    TARC_SKIP  = 2'b10
  } tarc_state_type;
endpackage

/* File: hw/tarc_reset_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tarc_defs.svh"
module tarc_reset_control (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       mosi_in,
  output logic [2:0]      setup_cfg_out,
  output logic [7:0]      ctrl_cfg_out,
  output logic            ready_out,
  output logic            reset_pulse_out
);
  import tarc_pkg::*;

  // ==========================================
  // Pin synchronisers
  logic [2:0] sclk_s_q, cs_s_q, mosi_s_q;
  logic       sclk_q, cs_n_q;
  always_ff @(posedge clk_in)
  begin
    sclk_s_q <= {sclk_s_q[1:0], sclk_in};
    cs_s_q   <= {cs_s_q[1:0], cs_n_in};
    mosi_s_q <= {mosi_s_q[1:0], mosi_in};
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end
    else
    begin
      if (sclk_s_q[1] == sclk_s_q[2])
        sclk_q <= sclk_s_q[2];
      if (cs_s_q[1] == cs_s_q[2])
        cs_n_q <= cs_s_q[2];
    end
  end
  wire sclk_rise = sclk_s_q[1] & sclk_s_q[2] & !sclk_q;
  wire selected  = !cs_n_q;
  wire data_bit  = mosi_s_q[2];

  // ==========================================
  // Shifters
  logic [23:0] key_q;
  logic [2:0]  bitcnt_q;
  logic        byte_ok_q;
  tarc_state_type state_q;
  logic [3:0]  por_cnt_q;
  wire  [7:0]  byte_now  = {key_q[6:0], data_bit};
  wire         byte_done = selected & sclk_rise & (bitcnt_q == 3'h7);
  wire         resync_hit = selected & sclk_rise
                            & ({key_q[22:0], data_bit} == `TARC_RESYNC_KEY); // see (RULE5)
  wire         iface_ok  = (state_q == TARC_READY);
  wire         sw_hit    = byte_done & iface_ok & byte_ok_q
                           & (byte_now == `TARC_SW_RESET_CODE); // see (RULE3)
  wire         is_setup  = byte_done & iface_ok & byte_now[`TARC_CTRL_START]
                           & (byte_now[`TARC_OP_MSB:`TARC_OP_LSB] == `TARC_SETUP_OPCODE);
  wire         is_ctrl   = byte_done & iface_ok & byte_now[`TARC_CTRL_START] & !sw_hit
                           & !is_setup;
  wire         soft_rst  = sw_hit | resync_hit; // see (RULE4)

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      key_q    <= 24'h000000;
      bitcnt_q <= 3'h0;
    end
    else if (resync_hit)
    begin
      key_q    <= 24'h000000;
      bitcnt_q <= 3'h0;
    end
    else if (selected & sclk_rise)
    begin
      key_q    <= {key_q[22:0], data_bit};
      bitcnt_q <= bitcnt_q + 3'h1;
    end
    else if (!selected)
      bitcnt_q <= 3'h0;
  end

  // Byte framing marked healthy on any deselect or completed non-reset byte; only reset clears it
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      byte_ok_q <= 1'b0;
    else if (!selected)
      byte_ok_q <= 1'b1;
    else if (byte_done & !sw_hit)
      byte_ok_q <= 1'b1;
  end

  // ==========================================
  // Power-on sequencer
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q   <= TARC_POR;
      por_cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        TARC_POR:
        begin
          por_cnt_q <= por_cnt_q + 4'h1;
          if (por_cnt_q == `TARC_POR_CYCLES)
            state_q <= TARC_READY; // see (RULE7)
        end
        // Resync keeps the sequencer ready
        TARC_READY:
          if (resync_hit)
            state_q <= TARC_READY;
        default:
          state_q <= TARC_POR;
      endcase
    end
  end

  // ==========================================
  // Configuration
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || soft_rst || state_q == TARC_POR)
    begin
      setup_cfg_out   <= `TARC_SETUP_DEFAULT; // see (RULE1)
      ctrl_cfg_out    <= `TARC_CTRL_DEFAULT;  // see (RULE2)
      reset_pulse_out <= rst_n_in & soft_rst;
    end
    else
    begin
      reset_pulse_out <= 1'b0;
      if (is_setup)
        setup_cfg_out <= byte_now[`TARC_SETUP_MSB:`TARC_SETUP_LSB];
      if (is_ctrl)
        ctrl_cfg_out <= byte_now;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      ready_out <= 1'b0;
    else
      ready_out <= (state_q == TARC_READY);
  end

  // ==========================================
  // Checks
  property p_resync_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
    resync_hit |=> (setup_cfg_out == `TARC_SETUP_DEFAULT) && (ctrl_cfg_out == `TARC_CTRL_DEFAULT)
                   && reset_pulse_out;
  endproperty
  a_resync_clears: assert property (p_resync_clears) else $error("resync did not reset"); // see (RULE4)
  property p_sw_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
    sw_hit |=> (ctrl_cfg_out == `TARC_CTRL_DEFAULT) && reset_pulse_out;
  endproperty
  a_sw_clears: assert property (p_sw_clears) else $error("soft reset ignored"); // see (RULE2)
  property p_setup_default;
    @(posedge clk_in) disable iff (!rst_n_in)
    soft_rst |=> setup_cfg_out == `TARC_SETUP_DEFAULT;
  endproperty
  a_setup_default: assert property (p_setup_default) else $error("setup not default"); // see (RULE1)
  property p_sw_needs_iface;
    @(posedge clk_in) disable iff (!rst_n_in)
    sw_hit |-> iface_ok;
  endproperty
  a_sw_needs_iface: assert property (p_sw_needs_iface) else $error("soft reset while down"); // see (RULE3)
  property p_resync_selected;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(reset_pulse_out) |-> $past(selected);
  endproperty
  a_resync_selected: assert property (p_resync_selected) else $error("reset while deselected"); // see (RULE5)
  property p_por_ready;
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_q == TARC_POR) |-> ##[1:17] (state_q == TARC_READY);
  endproperty
  a_por_ready: assert property (p_por_ready) else $error("POR never finished"); // see (RULE7)
  // Pulse never stretches
  property p_pulse_single;
    @(posedge clk_in) disable iff (!rst_n_in)
    reset_pulse_out |=> !reset_pulse_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("pulse too long"); // see (RULE4)
  // No reset from bits seen while deselected
  property p_deselect_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
    !selected |-> !soft_rst;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("reset while idle"); // see (RULE5)
  // Ready stays up once reached
  property p_ready_holds;
    @(posedge clk_in) disable iff (!rst_n_in)
    ready_out |=> ready_out;
  endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("ready dropped"); // see (RULE7)
  // Setup byte lands in setup bits
  property p_setup_loaded;
    @(posedge clk_in) disable iff (!rst_n_in)
    is_setup && !soft_rst |=> setup_cfg_out == $past(byte_now[`TARC_SETUP_MSB:`TARC_SETUP_LSB]);
  endproperty
  a_setup_loaded: assert property (p_setup_loaded) else $error("setup not stored"); // see (RULE1)
  // Control byte lands in control bits
  property p_ctrl_loaded;
    @(posedge clk_in) disable iff (!rst_n_in)
    is_ctrl && !soft_rst |=> ctrl_cfg_out == $past(byte_now);
  endproperty
  a_ctrl_loaded: assert property (p_ctrl_loaded) else $error("control not stored"); // see (RULE2)
endmodule
`default_nettype wire

/* File: verification/tarc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tarc_host_model (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ========
  // Frame of n bits, MSB first, 80 ns each
  task automatic send(input logic [31:0] bits, input int n, input logic sel);
    cs_n_out <= ~sel;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk_in) mosi_out <= bits[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    @(posedge clk_in) cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    // Deselect long enough for the filter to see it
    repeat (4) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: verification/touch_adc_reset_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module touch_adc_reset_control_tb_top;
  logic       clk_in    = 1'b0;
  logic       rst_n_in  = 1'b0;
  wire logic  sclk;
  wire logic  cs_n;
  wire logic  mosi;
  logic [2:0] setup_cfg;
  logic [7:0] ctrl_cfg;
  logic       ready;
  logic       pulse;
  logic [7:0] c;
  logic [7:0] s;
  int         bad_count = 0;
  int         checks    = 0;
  int         pulses    = 0;
  initial forever #4 clk_in = ~clk_in;
  tarc_host_model i_host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
  tarc_reset_control i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .setup_cfg_out(setup_cfg), .ctrl_cfg_out(ctrl_cfg),
    .ready_out(ready), .reset_pulse_out(pulse));
  always @(posedge clk_in) if (pulse === 1'b1) pulses <= pulses + 1;
  // ========
  // Checking
  function automatic logic [2:0] exp_setup(input logic [7:0] b);
    return b[3:1];
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Quiet gap after each software reset, over 200 ns
  task automatic settle;
    repeat (30) @(posedge clk_in);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    complete_run();
  end
  // ========
  // Sequence
  initial
  begin
    void'($urandom(3042));
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk_in);
    chk("ready", ready, 1);
    chk("setup", setup_cfg, 0);
    for (int k = 0; k < 4; k++)
    begin
      c = {2'b11, 6'($urandom)};
      s = {4'hA, 3'($urandom), 1'b0};
      i_host.send(c, 8, 1'b1);
      i_host.send(s, 8, 1'b1);
      settle;
      chk("ctrl", ctrl_cfg, c);
      chk("setup", setup_cfg, exp_setup(s));
      if (k[0])
        i_host.send({5'h15, 24'h06D926}, 29, 1'b1);
      else
        i_host.send(8'hA1, 8, 1'b1);
      settle;
      chk("pulses", pulses, k + 1);
      chk("setup", setup_cfg, 0);
      chk("ctrl", ctrl_cfg, 0);
    end
    i_host.send(24'h06D926, 24, 1'b0);
    settle;
    chk("pulses", pulses, 4);
    i_host.send(c, 8, 1'b1);
    settle;
    chk("ctrl", ctrl_cfg, c);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("ready", ready, 0);
    chk("ctrl", ctrl_cfg, 0);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk_in);
    chk("ready", ready, 1);
    chk("pulses", pulses, 4);
    complete_run();
  end
endmodule
`default_nettype wire
